// file: verilog/clk_cross_pkg.sv
// shared types and constants for the routed clock crossing block
// assumes one system bus clock; every other clock enters as a sampled signal, except that PIN_CLK also clocks the raw data flop
package clk_cross_pkg;
   // synchronizer depth: two stages
   localparam int SYNC_STAGES = 2;
   // synchronizer reset value
   localparam logic SYNC_RST = 1'h0;
   // width of the registered data path; the unrelated-domain crossing is a single bit
   localparam int DATA_W = 8;
   localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
   // output clock toggles once per bus clock edge: half the bus clock rate
   localparam logic TOGGLE_RST = 1'h0;
   // clock source modes
   typedef enum logic [1:0] {
      SRC_PIN_SYNC = 2'b00,
      SRC_PIN_RAW = 2'b01,
      SRC_SYNC_DOMAINS = 2'b10,
      SRC_ASYNC = 2'b11
   } src_mode_t;
   // data from the user side
   typedef struct packed {
      logic load;
      logic [DATA_W-1:0] data;
   } user_in_t;
   // observed state
   typedef struct packed {
      logic enable;
      logic [DATA_W-1:0] data;
   } user_out_t;
endpackage

// file: verilog/sync_2ff.sv
// two-stage synchronizer for one level
// assumes the input stays at a new level for at least one sampling period
`timescale 1ns/1ps
module sync_2ff (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // level in and out
   input wire logic din,
   output logic dout
);
   import clk_cross_pkg::*;
   logic meta_q;
   logic meta_d;
   logic out_q;
   logic out_d;

   always_comb begin
      meta_d = din;
      out_d = meta_q;
   end

   // latency one to two sampling periods, depending on alignment
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= SYNC_RST;
         out_q <= SYNC_RST;
      end else begin
         meta_q <= meta_d;
         out_q <= out_d;
      end
   end

   assign dout = out_q;
endmodule

// file: verilog/routed_clock_sync_crossing.sv
// routed clock crossing: pins and other domains brought onto the bus clock as enables
// assumes SYS_CLK is the bus clock and every foreign signal is unrelated to it
//
// How it works
// - synced pin clock: bus clock, edge enable
// - unsynced pin: routed clock drives the one raw flop
// - synchronous domain clocks: edge enable on bus
// - any async source: enable refused, only the pin clock used directly on the raw flop
// - registers get synchronous clocks, else synchronizer
// - crossing edges on bus edges, one cycle
// - synchronizer two flops, one-to-two cycle latency
// - no gated clocks: load or hold enable
// - output clock from toggle flop at half rate
// - peripheral signals synchronized, no timing assumed
// - enable on first edge after rising
`timescale 1ns/1ps
module routed_clock_sync_crossing (
   // system
   input wire logic SYS_CLK,
   input wire logic RST_N,
   // clock source selection, static strap levels from the user side
   input wire clk_cross_pkg::src_mode_t MODE,
   input wire logic ASYNC_OVERRIDE,
   // routed clock sources
   input wire logic PIN_CLK,
   input wire logic DOMAIN_A_CLK,
   input wire logic DOMAIN_B_CLK,
   // data from user logic on the bus clock
   input wire clk_cross_pkg::user_in_t USER_IN,
   // signal from a fixed-function peripheral
   input wire logic PERIPH_IN,
   // unrelated-domain level to cross
   input wire logic FOREIGN_LEVEL,
   // results
   output clk_cross_pkg::user_out_t USER_OUT,
   output logic RAW_DATA,
   output logic PERIPH_SYNC,
   output logic FOREIGN_SYNC,
   output logic CLK_OUT
);
   import clk_cross_pkg::*;

   // ---------------------------------------------------------------
   // synchronizers
   // ---------------------------------------------------------------
   logic pin_s;
   logic dom_a_s;
   logic dom_b_s;
   logic periph_s;
   logic foreign_s;
   logic async_s;
   logic [1:0] mode_s;

   // pin clock is a pin, so it is sampled before the edge logic sees it; only the raw flop takes it unsampled
   sync_2ff u_sync_pin (
      .clk(SYS_CLK),
      .rst_n(RST_N),
      .din(PIN_CLK),
      .dout(pin_s)
   );
   // domain clocks are bus-synchronous but still enter as foreign wires here
   sync_2ff u_sync_a (
      .clk(SYS_CLK),
      .rst_n(RST_N),
      .din(DOMAIN_A_CLK),
      .dout(dom_a_s)
   );
   sync_2ff u_sync_b (
      .clk(SYS_CLK),
      .rst_n(RST_N),
      .din(DOMAIN_B_CLK),
      .dout(dom_b_s)
   );
   sync_2ff u_sync_p (
      .clk(SYS_CLK),
      .rst_n(RST_N),
      .din(PERIPH_IN),
      .dout(periph_s)
   );
   sync_2ff u_sync_f (
      .clk(SYS_CLK),
      .rst_n(RST_N),
      .din(FOREIGN_LEVEL),
      .dout(foreign_s)
   );
   sync_2ff u_sync_o (
      .clk(SYS_CLK),
      .rst_n(RST_N),
      .din(ASYNC_OVERRIDE),
      .dout(async_s)
   );
   sync_2ff u_sync_m0 (
      .clk(SYS_CLK),
      .rst_n(RST_N),
      .din(MODE[0]),
      .dout(mode_s[0])
   );
   sync_2ff u_sync_m1 (
      .clk(SYS_CLK),
      .rst_n(RST_N),
      .din(MODE[1]),
      .dout(mode_s[1])
   );

   // ---------------------------------------------------------------
   // strap history
   // ---------------------------------------------------------------
   src_mode_t mode;
   src_mode_t mode_d;
   src_mode_t mode_q;
   src_mode_t mode_old_d;
   src_mode_t mode_old_q;
   logic mode_steady;

   always_comb begin
      mode = src_mode_t'(mode_s);
      // strap bits are synced apart and may skew a cycle; a change of source can fake an edge
      mode_d = mode;
      mode_old_d = mode_q;
      mode_steady = (mode == mode_q) && (mode_q == mode_old_q);
   end

   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         mode_q <= SRC_PIN_SYNC;
         mode_old_q <= SRC_PIN_SYNC;
      end else begin
         mode_q <= mode_d;
         mode_old_q <= mode_old_d;
      end
   end

   // ---------------------------------------------------------------
   // edge detection and source selection
   // ---------------------------------------------------------------
   logic routed_d;
   logic routed_q;
   logic hist_d;
   logic hist_q;
   logic raw_sel;
   logic rise_seen;
   logic en_d;
   logic en_q;

   always_comb begin
      // derived routed clock, an xor of two synchronous domain clocks
      if (mode == SRC_SYNC_DOMAINS) begin
         routed_d = dom_a_s ^ dom_b_s;
      end else begin
         routed_d = pin_s;
      end
      // raw path when the pin is unsynchronized, a source is async, or forced
      raw_sel = (mode == SRC_PIN_RAW) || (mode == SRC_ASYNC) || async_s;
      hist_d = routed_q;
      rise_seen = routed_q && !hist_q;
      // one bus-clock enable on the first edge after the routed rising edge
      en_d = !raw_sel && mode_steady && rise_seen;
   end

   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         routed_q <= SYNC_RST;
         hist_q <= SYNC_RST;
         en_q <= SYNC_RST;
      end else begin
         routed_q <= routed_d;
         hist_q <= hist_d;
         en_q <= en_d;
      end
   end

   // ---------------------------------------------------------------
   // pending load
   // ---------------------------------------------------------------
   logic load_d;
   logic load_q;
   logic load_now;

   always_comb begin
      // user load strobe is held by the bus clock flop until the enable takes it
      load_now = en_q && (load_q || USER_IN.load);
      load_d = load_q;
      if (USER_IN.load && !en_q) begin
         load_d = 1'b1;
      end else if (en_q) begin
         // a load that meets the enable is served at once, so none stays pending
         load_d = 1'b0;
      end
   end

   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         load_q <= SYNC_RST;
      end else begin
         load_q <= load_d;
      end
   end

   // ---------------------------------------------------------------
   // enabled datapath: load or hold, never a gated clock
   // ---------------------------------------------------------------
   logic [DATA_W-1:0] data_d;
   logic [DATA_W-1:0] data_q;

   always_comb begin
      data_d = data_q;
      if (load_now) begin
         data_d = USER_IN.data;
      end
   end

   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         data_q <= DATA_RST;
      end else begin
         data_q <= data_d;
      end
   end

   // ---------------------------------------------------------------
   // raw routed clock path
   // ---------------------------------------------------------------
   // only one bit is clocked by the raw pin; it stays outside the control and status path
   // limitation: the data bit must be steady around the pin edge, nothing retimes it
   logic raw_d;
   logic raw_q;

   always_comb begin
      raw_d = USER_IN.data[0];
   end

   always_ff @(posedge PIN_CLK or negedge RST_N) begin
      if (!RST_N) begin
         raw_q <= SYNC_RST;
      end else begin
         raw_q <= raw_d;
      end
   end

   // raw_q belongs to the pin domain, so it is resynchronized before leaving
   logic raw_s;
   sync_2ff u_sync_raw (
      .clk(SYS_CLK),
      .rst_n(RST_N),
      .din(raw_q),
      .dout(raw_s)
   );

   // ---------------------------------------------------------------
   // clock output
   // ---------------------------------------------------------------
   logic tog_d;
   logic tog_q;

   always_comb begin
      // toggles every bus edge, so CLK_OUT is half SYS_CLK
      tog_d = !tog_q;
   end

   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         tog_q <= TOGGLE_RST;
      end else begin
         tog_q <= tog_d;
      end
   end

   // ---------------------------------------------------------------
   // registered results
   // ---------------------------------------------------------------
   user_out_t out_d;
   user_out_t out_q;
   logic raw_out_d;
   logic raw_out_q;
   logic periph_d;
   logic periph_q;
   logic foreign_d;
   logic foreign_q;

   always_comb begin
      out_d.enable = en_q;
      // next data, not data_q, so a new word leaves together with its enable pulse
      out_d.data = data_d;
      raw_out_d = raw_s;
      periph_d = periph_s;
      foreign_d = foreign_s;
   end

   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         out_q.enable <= SYNC_RST;
         out_q.data <= DATA_RST;
         raw_out_q <= SYNC_RST;
         periph_q <= SYNC_RST;
         foreign_q <= SYNC_RST;
      end else begin
         out_q <= out_d;
         raw_out_q <= raw_out_d;
         periph_q <= periph_d;
         foreign_q <= foreign_d;
      end
   end

   assign USER_OUT = out_q;
   assign RAW_DATA = raw_out_q;
   assign PERIPH_SYNC = periph_q;
   assign FOREIGN_SYNC = foreign_q;
   assign CLK_OUT = tog_q;
endmodule

// file: testbench/far_user_logic.sv
// far-side user logic: routed pin clock and two synchronous domains
// assumes clk is the bus clock; all edges land just after its rising edge
`timescale 1ns/1ps
module far_user_logic (
   // bus clock
   input wire logic clk,
   // routed sources
   output logic pin_clk,
   output logic dom_a,
   output logic dom_b
);
   initial {pin_clk, dom_a, dom_b} = 3'h0;
   // high and low held whole cycles, never faster than half rate
   task automatic pulse(input int which, input int hi, input int lo);
      @(posedge clk);
      #1 if (which == 0) pin_clk = 1'b1; else dom_a = ~dom_a;
      repeat (hi) @(posedge clk);
      #1 if (which == 0) pin_clk = 1'b0; else dom_b = ~dom_b;
      repeat (lo) @(posedge clk);
   endtask
endmodule

// file: testbench/routed_clock_sync_crossing_props.sv
// port checker for the routed clock crossing
// assumes one bus clock; bound to the design below
`timescale 1ns/1ps
module routed_clock_sync_crossing_props (
   // watched ports
   input wire logic SYS_CLK,
   input wire logic RST_N,
   input wire clk_cross_pkg::src_mode_t MODE,
   input wire logic ASYNC_OVERRIDE,
   input wire logic PIN_CLK,
   input wire logic DOMAIN_A_CLK,
   input wire logic DOMAIN_B_CLK,
   input wire logic PERIPH_IN,
   input wire logic FOREIGN_LEVEL,
   input wire clk_cross_pkg::user_out_t USER_OUT,
   input wire logic RAW_DATA,
   input wire logic PERIPH_SYNC,
   input wire logic FOREIGN_SYNC,
   input wire logic CLK_OUT
);
   import clk_cross_pkg::*;
   logic [1:0] up_q;
   logic [1:0] up_d;
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (!RST_N);
   // $past looks into reset for three edges after release
   always_comb up_d = (up_q == 2'h3) ? up_q : up_q + 2'h1;
   always_ff @(posedge SYS_CLK or negedge RST_N) up_q <= !RST_N ? 2'h0 : up_d;
   a_periph_delay: assert property (up_q == 2'h3 |-> PERIPH_SYNC == $past(PERIPH_IN, 3))
      else $error("periph delay");
   a_foreign_delay: assert property (up_q == 2'h3 |-> FOREIGN_SYNC == $past(FOREIGN_LEVEL, 3))
      else $error("foreign delay");
   a_enable_single: assert property (USER_OUT.enable |=> !USER_OUT.enable)
      else $error("enable too long");
   a_data_hold: assert property ($changed(USER_OUT.data) |-> USER_OUT.enable)
      else $error("data moved");
   a_pin_enable: assert property (up_q == 2'h3 && $rose(PIN_CLK) && MODE == SRC_PIN_SYNC && !ASYNC_OVERRIDE
      |-> ##5 USER_OUT.enable) else $error("pin enable");
   a_domain_enable: assert property (up_q == 2'h3 && $rose(DOMAIN_A_CLK ^ DOMAIN_B_CLK)
      && MODE == SRC_SYNC_DOMAINS && !ASYNC_OVERRIDE |-> ##5 USER_OUT.enable) else $error("domain enable");
   a_raw_refused: assert property ((MODE[0] || ASYNC_OVERRIDE) [*8] |-> !USER_OUT.enable)
      else $error("enable when raw");
   a_clk_toggle: assert property ($past(RST_N) |-> CLK_OUT != $past(CLK_OUT))
      else $error("clock out stuck");
   a_reset_clear: assert property (disable iff (1'b0) !RST_N |-> USER_OUT == '0 && !CLK_OUT && !RAW_DATA
      && !PERIPH_SYNC && !FOREIGN_SYNC) else $error("reset values");
   c_enable: cover property (USER_OUT.enable);
   c_raw: cover property ($rose(RAW_DATA));
   c_foreign: cover property ($fell(FOREIGN_SYNC));
endmodule
bind routed_clock_sync_crossing routed_clock_sync_crossing_props u_props (.SYS_CLK(SYS_CLK), .RST_N(RST_N),
   .MODE(MODE), .ASYNC_OVERRIDE(ASYNC_OVERRIDE), .PIN_CLK(PIN_CLK), .DOMAIN_A_CLK(DOMAIN_A_CLK),
   .DOMAIN_B_CLK(DOMAIN_B_CLK), .PERIPH_IN(PERIPH_IN), .FOREIGN_LEVEL(FOREIGN_LEVEL), .USER_OUT(USER_OUT),
   .RAW_DATA(RAW_DATA), .PERIPH_SYNC(PERIPH_SYNC), .FOREIGN_SYNC(FOREIGN_SYNC), .CLK_OUT(CLK_OUT));

// file: testbench/tb_routed_clock_sync_crossing.sv
// bench for the routed clock crossing
// assumes the far-side model makes the routed clocks
`timescale 1ns/1ps
module tb_routed_clock_sync_crossing;
   import clk_cross_pkg::*;
   logic SYS_CLK = 1'b0;
   logic RST_N = 1'b1;
   src_mode_t MODE = SRC_PIN_SYNC;
   logic ASYNC_OVERRIDE = 1'b0;
   user_in_t USER_IN = '0;
   logic PERIPH_IN = 1'b0;
   logic FOREIGN_LEVEL = 1'b0;
   logic PIN_CLK, DOMAIN_A_CLK, DOMAIN_B_CLK, RAW_DATA, PERIPH_SYNC, FOREIGN_SYNC, CLK_OUT;
   user_out_t USER_OUT;
   int err_count = 0;
   int checks_done = 0;
   int n;
   always #4 SYS_CLK = ~SYS_CLK;
   far_user_logic u_far (.clk(SYS_CLK), .pin_clk(PIN_CLK), .dom_a(DOMAIN_A_CLK), .dom_b(DOMAIN_B_CLK));
   routed_clock_sync_crossing u_dut (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .MODE(MODE), .ASYNC_OVERRIDE(ASYNC_OVERRIDE),
      .PIN_CLK(PIN_CLK), .DOMAIN_A_CLK(DOMAIN_A_CLK), .DOMAIN_B_CLK(DOMAIN_B_CLK), .USER_IN(USER_IN),
      .PERIPH_IN(PERIPH_IN), .FOREIGN_LEVEL(FOREIGN_LEVEL), .USER_OUT(USER_OUT), .RAW_DATA(RAW_DATA),
      .PERIPH_SYNC(PERIPH_SYNC), .FOREIGN_SYNC(FOREIGN_SYNC), .CLK_OUT(CLK_OUT));
   task automatic chk1(input logic got, input logic exp);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %0t bit %b not %b", $time, got, exp);
      end
   endtask
   task automatic chk8(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %0t data %h not %h", $time, got, exp);
      end
   endtask
   task automatic close_out();
      $display("errors %0d checks %0d", err_count, checks_done);
      if (err_count == 0 && checks_done > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic step(input int k);
      repeat (k) @(posedge SYS_CLK);
      #1;
   endtask
   // one routed edge, enable pulses counted; a pending load rides along
   task automatic routed(input int which, input logic [DATA_W-1:0] d);
      USER_IN = '{1'b1, d};
      step(1);
      USER_IN.load = 1'b0;
      n = 0;
      fork
         u_far.pulse(which, 2, 2);
         repeat (12) begin @(posedge SYS_CLK); #1 n += USER_OUT.enable; end
      join
   endtask
   task automatic t_modes();
      routed(0, 8'hA5);
      chk1(n == 1, 1'b1);
      chk8(USER_OUT.data, 8'hA5);
      MODE = SRC_SYNC_DOMAINS;
      step(3);
      routed(1, 8'h3C);
      chk1(n == 1, 1'b1);
      chk8(USER_OUT.data, 8'h3C);
      for (int i = 0; i < 3; i++) begin
         case (i)
            0: MODE = SRC_PIN_RAW;
            1: MODE = SRC_ASYNC;
            default: MODE = SRC_PIN_SYNC;
         endcase
         ASYNC_OVERRIDE = i == 2;
         step(10);
         routed(0, 8'h5A);
         chk1(n == 0, 1'b1);
         chk8(USER_OUT.data, 8'h3C);
      end
   endtask
   task automatic t_raw();
      for (int v = 1; v >= 0; v--) begin
         MODE = SRC_PIN_RAW;
         routed(0, {7'h0, v[0]});
         chk1(RAW_DATA, v[0]);
      end
      MODE = SRC_PIN_SYNC;
      ASYNC_OVERRIDE = 1'b0;
      step(3);
      routed(0, 8'hC3);
      chk8(USER_OUT.data, 8'hC3);
   endtask
   task automatic t_sync();
      for (int v = 1; v >= 0; v--) begin
         PERIPH_IN = v[0];
         FOREIGN_LEVEL = v[0];
         step(2);
         chk1(FOREIGN_SYNC, ~v[0]);
         step(1);
         chk1(PERIPH_SYNC, v[0]);
         chk1(FOREIGN_SYNC, v[0]);
      end
      n = CLK_OUT;
      step(1);
      chk1(CLK_OUT, ~n[0]);
   endtask
   initial begin
      // a real falling edge, so the flops on the pin clock clear as well
      #1 RST_N = 1'b0;
      step(5);
      RST_N = 1'b1;
      step(3);
      t_modes();
      t_raw();
      t_sync();
      close_out();
   end
   initial begin
      #20000;
      err_count++;
      close_out();
   end
endmodule
